// File: verilog/oamd_decoder.sv
// operand address mode decoder: classifies an instruction, walks its
// operand specifiers and delivers operand locations to execute control
// assumes an asynchronous-read register file and a memory that acks reads
module oamd_decoder (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     start,
  input  wire logic [15:0]              instrWord,
  input  wire logic                     byteOp,
  input  wire logic [3:0]               processorStatusWord,
  output logic                          busy,
  output logic                          done,
  output oamd_pkg::oamd_group_t         group,
  output logic [2:0]                    accRegister,
  output logic                          operandValid,
  output logic                          operandIsDst,
  output logic                          operandIsReg,
  output logic                          operandIsImm,
  output logic [2:0]                    operandReg,
  output logic [15:0]                   operandAddr,
  output logic [15:0]                   operandValue,
  output logic                          branchTaken,
  output logic [15:0]                   branchTarget,
  output logic                          ccValid,
  output logic [3:0]                    ccResult,
  output logic [2:0]                    regRdSel,
  input  wire logic [15:0]              regRdData,
  output logic                          regWrEn,
  output logic [2:0]                    regWrSel,
  output logic [15:0]                   regWrData,
  output logic                          memReq,
  output logic [15:0]                   memAddr,
  input  wire logic                     memAck,
  input  wire logic [15:0]              memRdData
);
  import oamd_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CLASS, ST_EVAL, ST_PCLOAD, ST_EXT, ST_IND, ST_NEXT, ST_BRANCH, ST_CC
  } oamd_state_t;

  // ---------------------------------------------------------------
  // state and held values
  // ---------------------------------------------------------------
  oamd_state_t state;
  logic [15:0] instr;
  logic        isByte;
  logic        onDst;
  logic [15:0] baseVal;
  logic [15:0] pcVal;
  logic [5:0]  curSpec;
  logic [2:0]  mode;
  logic [2:0]  registerField;
  logic        isPc;
  logic        needExt;
  logic        needInd;
  logic [15:0] autoincStep;
  logic [15:0] next_stream_word;
  logic [15:0] idxSum;
  logic [15:0] decVal;
  logic        condMet;
  logic [15:0] next_branchTarget;
  oamd_group_t next_group;

  // the specifier being walked: source first for two-operand forms
  assign curSpec = onDst ? instr[DST_LSB +: 6] : instr[SRC_LSB +: 6]; // RULE_19

  oamd_spec_decode u_spec (
    .spec          (curSpec),
    .byteOp        (isByte),
    .mode          (mode),
    .registerField (registerField),
    .isPc          (isPc),
    .needExt       (needExt),
    .needInd       (needInd),
    .autoincStep   (autoincStep)
  );

  // ---------------------------------------------------------------
  // instruction classification
  // ---------------------------------------------------------------
  // group from the opcode bits of the 16-bit word
  always_comb begin
    next_group = GRP_MISC;
    if (instrWord[14:12] != 3'h0 && instrWord[14:12] != 3'h7) begin
      next_group = GRP_DOUBLE; // RULE_17
    end else if (instrWord[15:12] == 4'h7 || instrWord[15:9] == 7'h04) begin
      next_group = GRP_REGSD; // RULE_21
    end else if (instrWord[14:11] == 4'h0
                 && (instrWord[15] || instrWord[10:8] != 3'h0)) begin
      next_group = GRP_BRANCH;
    end else if (instrWord[15:5] == 11'h005) begin
      next_group = GRP_CCOP;
    end else if ((instrWord[14:12] == 3'h0
                  && (instrWord[11:9] == 3'h5 || instrWord[11:9] == 3'h6))
                 || instrWord[15:6] == 10'h001 || instrWord[15:6] == 10'h003) begin
      next_group = GRP_SINGLE; // RULE_18
    end
  end

  // branch condition from the status bits n z v c
  always_comb begin
    logic n, z, v, c;
    n = processorStatusWord[3];
    z = processorStatusWord[2];
    v = processorStatusWord[1];
    c = processorStatusWord[0];
    unique case ({instr[15], instr[10:8]})
      4'h0: condMet = 1'b0;
      4'h1: condMet = 1'b1;
      4'h2: condMet = ~z;
      4'h3: condMet = z;
      4'h4: condMet = ~(n ^ v);
      4'h5: condMet = n ^ v;
      4'h6: condMet = ~(z | (n ^ v));
      4'h7: condMet = z | (n ^ v);
      4'h8: condMet = ~n;
      4'h9: condMet = n;
      4'ha: condMet = ~(c | z);
      4'hb: condMet = c | z;
      4'hc: condMet = ~v;
      4'hd: condMet = v;
      4'he: condMet = ~c;
      4'hf: condMet = c;
    endcase
  end

  // index sum: pc modes see the pc after the extension fetch
  assign idxSum = next_stream_word + (isPc ? pcVal + STEP_PTR : baseVal); // RULE_10 RULE_15
  assign decVal = regRdData - autoincStep; // RULE_08
  assign next_stream_word = memRdData;
  // branch target formed this cycle so the pc write and the output agree
  assign next_branchTarget = regRdData + {{7{instr[7]}}, instr[7:0], 1'b0}; // RULE_22

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // walks specifiers and drives register file and memory requests
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= ST_IDLE;
      instr        <= ZERO_WORD;
      isByte       <= 1'b0;
      onDst        <= 1'b0;
      baseVal      <= ZERO_WORD;
      pcVal        <= ZERO_WORD;
      group        <= GRP_MISC;
      accRegister  <= 3'h0;
      regRdSel     <= 3'h0;
      regWrEn      <= 1'b0;
      regWrSel     <= 3'h0;
      regWrData    <= ZERO_WORD;
      memReq       <= 1'b0;
      memAddr      <= ZERO_WORD;
      operandValid <= 1'b0;
      operandIsDst <= 1'b0;
      operandIsReg <= 1'b0;
      operandIsImm <= 1'b0;
      operandReg   <= 3'h0;
      operandAddr  <= ZERO_WORD;
      operandValue <= ZERO_WORD;
      busy         <= 1'b0;
      done         <= 1'b0;
    end else begin
      regWrEn      <= 1'b0;
      operandValid <= 1'b0;
      done         <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (start) begin
            instr       <= instrWord; // RULE_02
            isByte      <= byteOp;
            group       <= next_group;
            accRegister <= instrWord[8:6]; // RULE_21
            onDst       <= (next_group != GRP_DOUBLE); // RULE_19 RULE_20
            busy        <= 1'b1;
            state       <= ST_CLASS;
          end
        end
        ST_CLASS: begin
          // operand groups load the specifier register; branches load pc, other groups need neither
          if (group == GRP_DOUBLE || group == GRP_SINGLE || group == GRP_REGSD) begin
            regRdSel <= registerField;
            state    <= ST_EVAL;
          end else if (group == GRP_BRANCH) begin
            regRdSel <= REG_PC;
            state    <= ST_BRANCH;
          end else if (group == GRP_CCOP) begin
            state <= ST_CC;
          end else begin
            state <= ST_NEXT;
          end
        end
        ST_EVAL: begin
          baseVal      <= regRdData;
          operandIsDst <= onDst;
          operandReg   <= registerField;
          operandIsReg <= 1'b0;
          operandIsImm <= 1'b0;
          if (needExt) begin
            regRdSel <= REG_PC; // RULE_12
            state    <= ST_PCLOAD;
          end else begin
            unique case (mode)
              MODE_REG: begin
                operandIsReg <= 1'b1; // RULE_03
                operandValid <= 1'b1;
                state        <= ST_NEXT;
              end
              MODE_DEF: begin
                operandAddr  <= regRdData; // RULE_04
                operandValid <= 1'b1;
                state        <= ST_NEXT;
              end
              MODE_AINC: begin
                operandAddr  <= regRdData; // RULE_05
                regWrEn      <= 1'b1;
                regWrSel     <= registerField;
                regWrData    <= regRdData + autoincStep; // RULE_05 RULE_06
                operandValid <= 1'b1;
                state        <= ST_NEXT;
              end
              MODE_AIND: begin
                memReq    <= 1'b1; // RULE_07
                memAddr   <= regRdData;
                regWrEn   <= 1'b1;
                regWrSel  <= registerField;
                regWrData <= regRdData + STEP_PTR; // RULE_07
                state     <= ST_IND;
              end
              MODE_ADEC: begin
                regWrEn      <= 1'b1;
                regWrSel     <= registerField;
                regWrData    <= decVal; // RULE_08
                operandAddr  <= decVal; // RULE_08
                operandValid <= 1'b1;
                state        <= ST_NEXT;
              end
              default: begin
                regWrEn   <= 1'b1; // RULE_09
                regWrSel  <= registerField;
                regWrData <= decVal;
                memReq    <= 1'b1;
                memAddr   <= decVal; // RULE_09
                state     <= ST_IND;
              end
            endcase
          end
        end
        ST_PCLOAD: begin
          pcVal   <= regRdData;
          memReq  <= 1'b1;
          memAddr <= regRdData;
          state   <= ST_EXT;
        end
        ST_EXT: begin
          if (memAck) begin
            memReq    <= 1'b0;
            regWrEn   <= 1'b1;
            regWrSel  <= REG_PC;
            regWrData <= pcVal + STEP_PTR; // RULE_24
            if (isPc && mode == MODE_AINC) begin
              operandIsImm <= 1'b1; // RULE_13
              operandValue <= next_stream_word; // RULE_13
              operandValid <= 1'b1;
              state        <= ST_NEXT;
            end else if (isPc && mode == MODE_AIND) begin
              operandAddr  <= next_stream_word; // RULE_14
              operandValid <= 1'b1;
              state        <= ST_NEXT;
            end else if (mode == MODE_IDX) begin
              operandAddr  <= idxSum; // RULE_10 RULE_15
              operandValid <= 1'b1;
              state        <= ST_NEXT;
            end else begin
              memAddr <= idxSum; // RULE_11 RULE_16
              state   <= ST_IND;
            end
          end
        end
        ST_IND: begin
          if (memAck && !memReq) begin
            memReq <= 1'b1;
          end else if (memAck) begin
            memReq       <= 1'b0;
            operandAddr  <= memRdData; // RULE_07 RULE_09 RULE_11 RULE_16
            operandValid <= 1'b1;
            state        <= ST_NEXT;
          end else begin
            memReq <= 1'b1;
          end
        end
        ST_NEXT: begin
          if (!onDst) begin
            onDst <= 1'b1; // RULE_19
            state <= ST_CLASS;
          end else begin
            busy  <= 1'b0;
            done  <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_BRANCH: begin
          if (condMet) begin
            regWrEn   <= 1'b1;
            regWrSel  <= REG_PC;
            regWrData <= next_branchTarget; // RULE_22
          end
          state <= ST_NEXT;
        end
        default: begin
          state <= ST_NEXT;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // branch and condition outputs
  // ---------------------------------------------------------------
  // branch target from the current pc and the word offset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      branchTarget <= ZERO_WORD;
      branchTaken  <= 1'b0;
    end else begin
      branchTaken <= (state == ST_BRANCH) && condMet;
      if (state == ST_CLASS) begin
        branchTarget <= ZERO_WORD;
      end else if (state == ST_BRANCH) begin
        branchTarget <= next_branchTarget; // RULE_22
      end
    end
  end

  // condition operators: bit four picks set or clear of the masked bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ccValid  <= 1'b0;
      ccResult <= 4'h0;
    end else begin
      ccValid <= (state == ST_CC);
      if (state == ST_CC) begin
        ccResult <= instr[CC_SET_B] ? (processorStatusWord | instr[3:0])
                                    : (processorStatusWord & ~instr[3:0]); // RULE_23
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_ext_ack;
    (state == ST_EXT) && memAck;
  endsequence
  sequence s_pc_bump;
    regWrEn && (regWrSel == REG_PC);
  endsequence

  a_ext_pc_bump: assert property ( // RULE_24
    s_ext_ack |=> s_pc_bump ##0 (regWrData == $past(pcVal) + STEP_PTR))
    else $error("extension fetch did not advance pc by two");
  a_autoinc_step: assert property ( // RULE_05
    (state == ST_EVAL && !needExt && mode == MODE_AINC)
    |=> regWrEn && operandValid && (regWrData == operandAddr + $past(autoincStep)))
    else $error("auto-increment update wrong");
  a_step_size: assert property ( // RULE_06
    autoincStep == (isByte ? 16'h0001 : 16'h0002))
    else $error("auto step not matched to operand size");
  a_ptr_step: assert property ( // RULE_07
    (state == ST_EVAL && !needExt && mode == MODE_AIND)
    |=> regWrEn && (regWrData == memAddr + 16'h0002) && memReq)
    else $error("deferred increment not by two");
  a_autodec_addr: assert property ( // RULE_08
    (state == ST_EVAL && !needExt && mode == MODE_ADEC)
    |=> operandValid && (operandAddr == regWrData)
        && (regWrData == $past(regRdData) - $past(autoincStep)))
    else $error("auto-decrement address wrong");
  a_mode0_reg: assert property ( // RULE_03
    (state == ST_EVAL && mode == MODE_REG) |=> operandIsReg && operandValid && !memReq)
    else $error("register mode touched memory");
  a_imm_value: assert property ( // RULE_13
    (s_ext_ack ##0 isPc && mode == MODE_AINC)
    |=> operandIsImm && operandValid && (operandValue == $past(memRdData)))
    else $error("immediate operand not the stream word");
  a_branch_load: assert property ( // RULE_22
    (state == ST_BRANCH && condMet)
    |=> s_pc_bump ##0 branchTaken
        ##0 (regWrData == $past(regRdData) + {{7{instr[7]}}, instr[7:0], 1'b0}))
    else $error("taken branch target wrong");
  a_cc_update: assert property ( // RULE_23
    (state == ST_CC && instr[CC_SET_B]) |=> ccValid && ((ccResult & instr[3:0]) == instr[3:0]))
    else $error("condition set operator missed a bit");
  a_src_then_dst: assert property ( // RULE_19
    (operandValid && !operandIsDst) |-> ##[1:8] (state == ST_EVAL) && onDst)
    else $error("destination not walked after source");
  a_ind_entry: assert property ( // RULE_17
    (state == ST_IND && $past(state) != ST_IND) |-> $past(needInd))
    else $error("pointer read without a deferred mode");
endmodule

// File: verilog/oamd_pkg.sv
// constants and types shared by the operand address mode decoder
// assumes a 16-bit word machine whose register seven is the program counter
// Operation
// [RULE_01] specifier is mode plus three-bit register
// [RULE_02] instructions are 16-bit words holding specifiers
// [RULE_03] mode 0 uses the register itself
// [RULE_04] mode 1 register holds operand address
// [RULE_05] mode 2 use address then increment register
// [RULE_06] step is two for words, one bytes
// [RULE_07] mode 3 reads pointer, register plus two
// [RULE_08] mode 4 decrement first, then use address
// [RULE_09] mode 5 decrement, read pointer word there
// [RULE_10] mode 6 index word plus register addresses
// [RULE_11] mode 7 index plus register addresses pointer
// [RULE_12] register seven selects program counter variants
// [RULE_13] mode 2 on pc gives immediate word
// [RULE_14] mode 3 on pc gives absolute address
// [RULE_15] mode 6 on pc adds updated pc
// [RULE_16] mode 7 on pc reads pointer there
// [RULE_17] double operand fields; mode low bit defers
// [RULE_18] single operand opcode high, destination low
// [RULE_19] source decoded first, then destination
// [RULE_20] single operand decodes destination only
// [RULE_21] register group names accumulator register
// [RULE_22] taken branch loads pc plus twice offset
// [RULE_23] condition operators set or clear bits
// [RULE_24] extension fetch bumps pc by two first
package oamd_pkg;
  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int         WORD_W    = 16;
  localparam int         SRC_LSB   = 6;
  localparam int         DST_LSB   = 0;
  localparam int         CC_SET_B  = 4;
  localparam logic [2:0] REG_PC    = 3'h7;
  localparam logic [2:0] MODE_REG  = 3'h0;
  localparam logic [2:0] MODE_DEF  = 3'h1;
  localparam logic [2:0] MODE_AINC = 3'h2;
  localparam logic [2:0] MODE_AIND = 3'h3;
  localparam logic [2:0] MODE_ADEC = 3'h4;
  localparam logic [2:0] MODE_ADED = 3'h5;
  localparam logic [2:0] MODE_IDX  = 3'h6;
  localparam logic [2:0] MODE_IDXD = 3'h7;
  // ---------------------------------------------------------------
  // steps and reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_PTR  = 16'h0002;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  // ---------------------------------------------------------------
  // instruction groups
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    GRP_DOUBLE, GRP_SINGLE, GRP_REGSD, GRP_BRANCH, GRP_MISC, GRP_CCOP
  } oamd_group_t;
endpackage

// File: verilog/oamd_spec_decode.sv
// splits one six-bit operand specifier into its mode and register parts
// assumes the caller selects which specifier of the instruction to present
module oamd_spec_decode (
  input  wire logic [5:0]  spec,
  input  wire logic        byteOp,
  output logic      [2:0]  mode,
  output logic      [2:0]  registerField,
  output logic             isPc,
  output logic             needExt,
  output logic             needInd,
  output logic      [15:0] autoincStep
);
  import oamd_pkg::*;

  // mode in the upper three bits, register in the lower three
  assign mode          = spec[5:3]; // RULE_01
  assign registerField = spec[2:0]; // RULE_01
  assign isPc          = (spec[2:0] == REG_PC); // RULE_12
  // index modes and pc modes 2 and 3 take a word from the stream
  assign needExt = (mode == MODE_IDX) || (mode == MODE_IDXD)
                 || (isPc && ((mode == MODE_AINC) || (mode == MODE_AIND))); // RULE_12
  // low mode bit marks deferral; absolute and mode 1 need no pointer read
  assign needInd = mode[0] && (mode != MODE_DEF)
                 && !(isPc && (mode == MODE_AIND)); // RULE_17
  assign autoincStep = byteOp ? STEP_BYTE : STEP_WORD; // RULE_06
endmodule

// File: tb/oamd_partner_model.sv
// partner model: register file with the program counter as register seven, and word memory
// assumes the decoder holds memReq and its address until it samples memAck high
module oamd_partner_model (
  input  wire logic        clk,
  input  wire logic [2:0]  regRdSel,
  output logic      [15:0] regRdData,
  input  wire logic        regWrEn,
  input  wire logic [2:0]  regWrSel,
  input  wire logic [15:0] regWrData,
  input  wire logic        memReq,
  input  wire logic [15:0] memAddr,
  output logic             memAck,
  output logic      [15:0] memRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] regs [8];
  logic [15:0] mem  [256];
  int          ackDelay = 0;
  int          waitCnt  = 0;
  logic        cool     = 1'b0;
  initial begin
    memAck    = 1'b0;
    memRdData = 16'h5a5a;
  end
  // combinational read, register seven is the program counter
  assign regRdData = regs[regRdSel];
  // register writes land at the edge
  always @(posedge clk) begin
    if (regWrEn) regs[regWrSel] <= regWrData;
  end
  // one ack per request, after ackDelay idle cycles; data toggles outside the ack
  always @(posedge clk) begin
    memAck    <= 1'b0;
    cool      <= memAck;
    memRdData <= ~memRdData;
    if (memReq && !memAck && !cool) begin
      if (waitCnt >= ackDelay) begin
        memAck    <= 1'b1;
        memRdData <= mem[memAddr[8:1]];
        waitCnt   <= 0;
      end else begin
        waitCnt <= waitCnt + 1;
      end
    end
  end
endmodule

// File: tb/tb_top.sv
// self-checking bench for the operand address mode decoder
// assumes the partner model stands in for the register file and memory
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import oamd_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        start = 1'b0;
  logic        byteOp = 1'b0;
  logic [15:0] instrWord = 16'h0000;
  logic [3:0]  processorStatusWord = 4'h0;
  logic        busy, done, operandValid, operandIsDst, operandIsReg, operandIsImm;
  logic        branchTaken, ccValid, regWrEn, memReq, memAck;
  logic [2:0]  accRegister, operandReg, regRdSel, regWrSel;
  logic [3:0]  ccResult;
  logic [15:0] operandAddr, operandValue, branchTarget, regRdData, regWrData;
  logic [15:0] memAddr, memRdData;
  oamd_group_t group;
  logic [15:0] opAddr [2];
  logic [15:0] opVal  [2];
  logic [2:0]  opKind [2];
  logic        brSeen;
  logic [3:0]  ccSeen;
  int          nOps;
  int          bad_count = 0;
  int          tests_run = 0;
  int          cycles = 0;

  oamd_decoder oamd_decoder_i (
    .clk, .rst_n, .start, .instrWord, .byteOp, .processorStatusWord, .busy, .done, .group,
    .accRegister, .operandValid, .operandIsDst, .operandIsReg, .operandIsImm, .operandReg,
    .operandAddr, .operandValue, .branchTaken, .branchTarget, .ccValid, .ccResult,
    .regRdSel, .regRdData, .regWrEn, .regWrSel, .regWrData, .memReq, .memAddr, .memAck,
    .memRdData
  );
  oamd_partner_model oamd_partner_model_i (
    .clk, .regRdSel, .regRdData, .regWrEn, .regWrSel, .regWrData, .memReq, .memAddr,
    .memAck, .memRdData
  );

  // clock and hang limit
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic setr(input int r, input logic [15:0] v);
    oamd_partner_model_i.regs[r] = v;
  endtask

  function automatic logic [15:0] getr(input int r);
    return oamd_partner_model_i.regs[r];
  endfunction

  // issue one instruction and record operand and branch pulses until done
  task automatic run(input logic [15:0] iw, input logic bw);
    int n;
    nOps = 0;
    brSeen = 1'b0;
    ccSeen = 4'hx;
    instrWord = iw;
    byteOp = bw;
    start = 1'b1;
    @(posedge clk) #1 start = 1'b0;
    for (n = 0; n < 200 && done !== 1'b1; n++) begin
      if (operandValid === 1'b1 && nOps < 2) begin
        opAddr[nOps] = operandAddr;
        opVal[nOps]  = operandValue;
        opKind[nOps] = {operandIsDst, operandIsReg, operandIsImm};
        nOps++;
      end
      if (branchTaken === 1'b1) brSeen = 1'b1;
      if (ccValid === 1'b1) ccSeen = ccResult;
      @(posedge clk) #1;
    end
    chk(16'({n < 200, busy}), 16'h0002, "instruction completes, busy low");
  endtask

  // auto-increment by word and byte step
  task automatic t_autoinc();
    for (int b = 0; b < 2; b++) begin
      setr(3, 16'h0040);
      run(b ? 16'h8a13 : 16'h0a13, b[0]);
      chk(16'(nOps), 16'h0001, "single operand count");
      chk(opAddr[0], 16'h0040, "autoinc address");
      chk({13'h0, opKind[0]}, 16'h0004, "autoinc kind");
      chk(getr(3), b ? 16'h0041 : 16'h0042, "autoinc step");
    end
  endtask

  // register and register-deferred leave the register alone
  task automatic t_regdef();
    setr(5, 16'h0123);
    run(16'h0a05, 1'b0);
    chk({13'h0, opKind[0]}, 16'h0006, "register operand kind");
    run(16'h0a0d, 1'b0);
    chk(opAddr[0], 16'h0123, "deferred address");
    chk(getr(5), 16'h0123, "deferred register kept");
    chk({13'h0, operandReg}, 16'h0005, "operand register field");
  endtask

  // auto-decrement before use, both sizes
  task automatic t_autodec();
    for (int b = 0; b < 2; b++) begin
      setr(2, 16'h0080);
      run(b ? 16'h8a22 : 16'h0a22, b[0]);
      chk(opAddr[0], b ? 16'h007f : 16'h007e, "autodec address");
      chk(getr(2), b ? 16'h007f : 16'h007e, "autodec register");
    end
  endtask

  // pointer mode with a byte instruction and a slow memory still steps by two
  task automatic t_pointer();
    oamd_partner_model_i.ackDelay = 3;
    setr(4, 16'h0060);
    oamd_partner_model_i.mem[8'h30] = 16'h1234;
    run(16'h8a1c, 1'b1);
    chk(opAddr[0], 16'h1234, "pointer address");
    chk(getr(4), 16'h0062, "pointer step");
    oamd_partner_model_i.ackDelay = 0;
  endtask

  // program counter modes: relative, absolute, immediate source
  task automatic t_pcmodes();
    oamd_partner_model_i.mem[8'h80] = 16'h0010;
    setr(7, 16'h0100);
    run(16'h0a37, 1'b0);
    chk(opAddr[0], 16'h0112, "relative address");
    chk(getr(7), 16'h0102, "pc after extension");
    setr(7, 16'h0100);
    run(16'h0a1f, 1'b0);
    chk(opAddr[0], 16'h0010, "absolute address");
    setr(7, 16'h0100);
    run(16'h15c1, 1'b0);
    chk({13'h0, opKind[0]}, 16'h0001, "immediate kind");
    chk(opVal[0], 16'h0010, "immediate value");
    chk({13'h0, opKind[1]}, 16'h0006, "register destination");
    chk(getr(7), 16'h0102, "pc after immediate");
  endtask

  // double operand: source first, then destination, each its own mode
  task automatic t_double();
    setr(1, 16'h0050);
    setr(2, 16'h0090);
    run(16'h1262, 1'b0);
    chk(16'(group), 16'(GRP_DOUBLE), "double group");
    chk(16'(nOps), 16'h0002, "two operands");
    chk({opAddr[0][12:0], opKind[0]}, {13'h0050, 3'h0}, "source operand");
    chk({opAddr[1][12:0], opKind[1]}, {13'h008e, 3'h4}, "destination operand");
    run(16'h70c1, 1'b0);
    chk(16'(group), 16'(GRP_REGSD), "register group");
    chk({13'h0, accRegister}, 16'h0003, "accumulator register");
  endtask

  // decrement deferred, indexed, index deferred and relative deferred
  task automatic t_deferred();
    logic [15:0] iw   [4] = '{16'h0a29, 16'h0a31, 16'h0a39, 16'h0a3f};
    logic [15:0] want [4] = '{16'h2222, 16'h0072, 16'h4444, 16'h3456};
    oamd_partner_model_i.mem[8'h31] = 16'h2222;
    oamd_partner_model_i.mem[8'h39] = 16'h4444;
    oamd_partner_model_i.mem[8'h89] = 16'h3456;
    setr(1, 16'h0064);
    for (int i = 0; i < 4; i++) begin
      setr(7, 16'h0100);
      run(iw[i], 1'b0);
      chk(opAddr[0], want[i], "deferred or indexed address");
    end
    chk(getr(1), 16'h0062, "decrement deferred register");
  endtask

  // condition operators: set then clear selected bits
  task automatic t_ccop();
    processorStatusWord = 4'h5;
    run(16'h00ba, 1'b0);
    chk(16'(group), 16'(GRP_CCOP), "condition operator group");
    chk({12'h0, ccSeen}, 16'h000f, "condition set");
    run(16'h00a5, 1'b0);
    chk({12'h0, ccSeen}, 16'h0000, "condition clear");
  endtask

  // branches: unconditional, condition false and true, negative offset
  task automatic t_branch();
    logic [15:0] iw  [4] = '{16'h0105, 16'h0305, 16'h0305, 16'h01fe};
    logic [3:0]  ps  [4] = '{4'h0, 4'h0, 4'h4, 4'h0};
    logic [15:0] tgt [4] = '{16'h010a, 16'h0100, 16'h010a, 16'h00fc};
    for (int i = 0; i < 4; i++) begin
      setr(7, 16'h0100);
      processorStatusWord = ps[i];
      run(iw[i], 1'b0);
      chk(16'(brSeen), 16'(tgt[i] != 16'h0100), "branch decision");
      chk(getr(7), tgt[i], "pc after branch");
    end
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    t_autoinc();
    t_regdef();
    t_autodec();
    t_pointer();
    t_pcmodes();
    t_deferred();
    t_double();
    t_ccop();
    t_branch();
    give_verdict();
  end
endmodule
